/* tb/t3cg_far_model.sv */
// far side: external count clock source and serial tick counter
`timescale 1ns/10ps
module t3cg_far_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // pin drive request
  input  wire logic pin_en,
  // count pin and serial ticks
  output logic      ext_pin,
  output int        falls,
  input  wire logic rx_tick,
  input  wire logic tx_tick,
  output int        rx_n,
  output int        tx_n
);
  int ph;
  //////////////////////////////////////////////////////////////
  // pin level flips every 3 cycles; a low phase always ends high (pull-up)
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_pin <= 1'b1;
      ph      <= 0;
      falls   <= 0;
    end else if (pin_en || !ext_pin) begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (ph == 2) ext_pin <= ~ext_pin;
      if (ph == 2 && ext_pin) falls <= falls + 1;
    end else begin
      ph <= 0;
    end
  end
  // serial side counts the ticks it is handed
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_n <= 0;
      tx_n <= 0;
    end else begin
      rx_n <= rx_n + int'(rx_tick);
      tx_n <= tx_n + int'(tx_tick);
    end
  end
endmodule

/* tb/t3cg_top_tb.sv */
// self-checking bench for the third timer block
`timescale 1ns/10ps
module t3cg_top_tb;
  logic       mclk, nrst, reg_wr, reg_rd, strobe, pin_en, rd_seen;
  logic       ext_pin, ck_out, ck_oe, rx_tick, tx_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lo;
  logic [7:0] expq[$];
  int         bad_count, n_tests, cyc, rx_n, tx_n, falls, n, rx0, tx0, f0;
  logic [7:0] bcode[6] = '{8'h34, 8'h24, 8'h14, 8'h36, 8'h26, 8'h16};
  logic [7:0] scode[4] = '{8'h00, 8'h08, 8'h01, 8'h09};
  logic [7:0] ccode[4] = '{8'h02, 8'h0A, 8'h03, 8'h0B};

  t3cg_top #(.TIMER_DIV(12)) i_t3cg_top (
    .mclk(mclk), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_count_clock_pin_in(ext_pin), .capture_reload_strobe_pin_in(strobe),
    .clock_out_pin_out(ck_out), .clock_out_pin_oe(ck_oe),
    .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick));
  t3cg_far_model i_t3cg_far_model (
    .mclk(mclk), .nrst(nrst), .pin_en(pin_en), .ext_pin(ext_pin), .falls(falls),
    .rx_tick(rx_tick), .tx_tick(tx_tick), .rx_n(rx_n), .tx_n(tx_n));

  //////////////////////////////////////////////////////////////
  // clock and cycle count
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    expq.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // spacing of 2nd and 3rd event: 0 clock-out edge, 1 rx tick, 2 tx tick
  task automatic gap(input int w, input int e);
    int   t0;
    int   k;
    logic p;
    logic h;
    t0 = -1;
    k  = 0;
    p  = ck_out;
    for (int i = 0; i < 8000; i++) begin
      @(posedge mclk);
      #1;
      h = (w == 0) ? (ck_out !== p) : (w == 1) ? rx_tick : tx_tick;
      p = ck_out;
      if (h) k++;
      if (h && k == 3) break;
      if (h) t0 = cyc;
    end
    chk(16'(cyc - t0), 16'(e));
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_seen <= reg_rd;
    if (rd_seen && expq.size() > 0) begin
      chk({8'h00, reg_rdata}, {8'h00, expq.pop_front()});
    end
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////
  initial begin
    {nrst, reg_wr, reg_rd, strobe, pin_en} = 5'b00010;
    {reg_addr, reg_wdata} = 16'h0000;
    void'($urandom(75));
    lo = 8'hF0 + 8'($urandom % 8);
    n  = 256 - int'(lo);
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    // reset values, unmapped place, implemented mode bits
    for (int a = 8'hC7; a <= 8'hCD; a++) rd(8'(a), 8'h00);
    wr(t3cg_pkg::ADDR_MODE, 8'hFF);
    rd(t3cg_pkg::ADDR_MODE, t3cg_pkg::MODE_MASK);
    $display("test reset values done");
    // clock output alone
    wr(t3cg_pkg::ADDR_RELOAD_LO, lo);
    wr(t3cg_pkg::ADDR_RELOAD_HI, 8'hFF);
    wr(t3cg_pkg::ADDR_COUNT_LO, lo);
    wr(t3cg_pkg::ADDR_COUNT_HI, 8'hFF);
    wr(t3cg_pkg::ADDR_MODE, 8'h02);
    wr(t3cg_pkg::ADDR_CONTROL, 8'h04);
    gap(0, 2 * n);
    chk(16'(ck_oe), 16'h0001);
    wr(t3cg_pkg::ADDR_CONTROL, 8'h00);
    rd(t3cg_pkg::ADDR_CONTROL, 8'h00);
    $display("test clock output done");
    // baud codes, internal and pin clocked, clock output beside the internal ones
    foreach (bcode[i]) begin
      wr(t3cg_pkg::ADDR_CONTROL, bcode[i]);
      pin_en <= bcode[i][1];
      rx0 = rx_n;
      tx0 = tx_n;
      gap(bcode[i][5] ? 1 : 2, (bcode[i][1] ? 96 : 32) * n);
      chk(16'(bcode[i][5] ? 0 : rx_n - rx0), 16'h0000);
      chk(16'(bcode[i][4] ? 0 : tx_n - tx0), 16'h0000);
      chk(16'(ck_oe), 16'(!bcode[i][1]));
      if (!bcode[i][1]) gap(0, 2 * n);
      rd(t3cg_pkg::ADDR_CONTROL, bcode[i]);
    end
    pin_en <= 1'b0;
    // strobe edge in baud mode: flag only, no capture or reload
    wr(t3cg_pkg::ADDR_CONTROL, 8'h3D);
    strobe <= 1'b0;
    repeat (3) @(posedge mclk);
    strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(t3cg_pkg::ADDR_CONTROL, 8'h7D);
    rd(t3cg_pkg::ADDR_RELOAD_HI, 8'hFF);
    wr(t3cg_pkg::ADDR_CONTROL, 8'h00);
    wr(t3cg_pkg::ADDR_MODE, 8'h00);
    $display("test baud generator done");
    // strobe falling edge on reload and capture codes
    foreach (scode[i]) begin
      wr(t3cg_pkg::ADDR_RELOAD_LO, 8'h00);
      wr(t3cg_pkg::ADDR_RELOAD_HI, 8'hAB);
      wr(t3cg_pkg::ADDR_COUNT_LO, 8'h00);
      wr(t3cg_pkg::ADDR_COUNT_HI, 8'h00);
      wr(t3cg_pkg::ADDR_CONTROL, scode[i]);
      wr(t3cg_pkg::ADDR_CONTROL, scode[i] | 8'h04);
      strobe <= 1'b0;
      repeat (3) @(posedge mclk);
      strobe <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(t3cg_pkg::ADDR_CONTROL, scode[i] | 8'h04 | ((scode[i] << 3) & 8'h40));
      wr(t3cg_pkg::ADDR_CONTROL, scode[i]);
      rd(scode[i][0] ? t3cg_pkg::ADDR_RELOAD_HI : t3cg_pkg::ADDR_COUNT_HI,
         (scode[i][0] ^ scode[i][3]) ? 8'hAB : 8'h00);
    end
    $display("test strobe control done");
    // counter codes count pin falls
    foreach (ccode[i]) begin
      wr(t3cg_pkg::ADDR_COUNT_LO, 8'h00);
      wr(t3cg_pkg::ADDR_COUNT_HI, 8'h00);
      wr(t3cg_pkg::ADDR_CONTROL, ccode[i]);
      wr(t3cg_pkg::ADDR_CONTROL, ccode[i] | 8'h04);
      f0 = falls;
      pin_en <= 1'b1;
      repeat (40) @(posedge mclk);
      pin_en <= 1'b0;
      repeat (12) @(posedge mclk);
      wr(t3cg_pkg::ADDR_CONTROL, ccode[i]);
      rd(t3cg_pkg::ADDR_COUNT_LO, 8'(falls - f0));
    end
    $display("test counter done");
    // down count with strobe level low: underflow at reload loads top, sets flag
    wr(t3cg_pkg::ADDR_CONTROL, 8'h00);
    wr(t3cg_pkg::ADDR_MODE, 8'h01);
    wr(t3cg_pkg::ADDR_RELOAD_LO, 8'h00);
    wr(t3cg_pkg::ADDR_RELOAD_HI, 8'h00);
    wr(t3cg_pkg::ADDR_COUNT_LO, 8'h03);
    wr(t3cg_pkg::ADDR_COUNT_HI, 8'h00);
    strobe <= 1'b0;
    wr(t3cg_pkg::ADDR_CONTROL, 8'h04);
    repeat (54) @(posedge mclk);
    rd(t3cg_pkg::ADDR_CONTROL, 8'h84);
    wr(t3cg_pkg::ADDR_CONTROL, 8'h00);
    rd(t3cg_pkg::ADDR_COUNT_HI, 8'hFF);
    strobe <= 1'b1;
    wr(t3cg_pkg::ADDR_MODE, 8'h00);
    $display("test down count done");
    repeat (2) @(posedge mclk);
    end_of_test();
  end
endmodule

/* verilog/t3cg_edge_if.sv */
// interface between a pin synchroniser and the timer core
`timescale 1ns/10ps
interface t3cg_edge_if;
  logic pin_raw;
  logic level;
  logic fall;
  modport det (input pin_raw, output level, output fall);
  modport use_side (output pin_raw, input level, input fall);
endinterface

/* verilog/t3cg_pin_sync.sv */
// two-flop pin synchroniser with falling-edge detect
`timescale 1ns/10ps
module t3cg_pin_sync (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // pin side and synchronised side
  t3cg_edge_if.det pin
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // pins idle high, so flops reset high to avoid a false edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (ce) begin
      meta_q <= pin.pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // level and one-cycle falling pulse from synchronised flops only
  assign pin.level = sync_q;
  assign pin.fall  = ce & prev_q & ~sync_q;
endmodule

/* verilog/t3cg_pkg.sv */
// constants for the third timer: register map, fields, reset values, dividers
package t3cg_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] ADDR_CONTROL   = 8'hC8;
  localparam logic [7:0] ADDR_MODE      = 8'hC9;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;
  // control register fields
  localparam int CTL_OVF_FLAG = 7;
  localparam int CTL_EXT_FLAG = 6;
  localparam int CTL_RX_CLK   = 5;
  localparam int CTL_TX_CLK   = 4;
  localparam int CTL_EXT_EN   = 3;
  localparam int CTL_RUN      = 2;
  localparam int CTL_CTS      = 1;
  localparam int CTL_CAPTURE  = 0;
  // mode register fields and implemented-bit mask
  localparam int MODE_CLK_OUT = 1;
  localparam int MODE_DOWN    = 0;
  localparam logic [7:0] MODE_MASK = 8'h03;
  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
  // timing: one state time is two oscillator clocks, serial divides by sixteen
  localparam int STATE_DIV = 2;
  localparam int BAUD_DIV  = 16;
  localparam logic [3:0] BAUD_LAST = 4'(BAUD_DIV - 1);
endpackage

/* verilog/t3cg_top.sv */
// third timer: auto-reload, capture, counter, clock output, baud generator
// Contract
// R1 - clock out: select clear, enable set, run
// R2 - clock out = osc / (4 x (65536-reload))
// R3 - no overflow flag in clock-out mode
// R4 - baud and clock out share one overflow
// R5 - baud mode counts state times or pin edges
// R6 - software stops timer before count access
// R7 - software avoids reload writes while generating baud
// R8 - external clock baud = overflow rate / 16
// R9 - internal baud = osc / (32 x (65536-reload))
// R10 - control bytes select reload/capture, external strobe
// R11 - control bytes select receive/transmit baud clocks
// R12 - software sets run bit separately
// R13 - counter mode bytes select 16-bit/auto-reload
// R14 - internal control: capture/reload only on overflow
// R15 - strobe falling edge acts, except baud mode; the code also gives it no capture or reload in down-count mode, only the flag
// R16 - shared pin serves as external count clock
// R17 - mode register: bit1 clock out, bit0 down
// R18 - overflow reloads, toggles clock or advances baud
`timescale 1ns/10ps
module t3cg_top #(
  parameter int TIMER_DIV = 12
) (
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       ext_count_clock_pin_in,
  input  wire logic       capture_reload_strobe_pin_in,
  output logic            clock_out_pin_out,
  output logic            clock_out_pin_oe,
  // serial port ticks
  output logic            rx_baud_tick,
  output logic            tx_baud_tick
);
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  mode_q;
  logic [15:0] rld_q;
  logic [15:0] rld_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [3:0]  pre_q;
  logic [3:0]  pre_lim;
  logic [3:0]  baud_cnt_q;
  logic        baud_tick_q;
  logic        clk_q;
  logic        run;
  logic        cts;
  logic        exen;
  logic        baud;
  logic        clkout_mode;
  logic        fast;
  logic        capmode;
  logic        updown;
  logic        count_up;
  logic        pre_tick;
  logic        inc;
  logic        ovf;
  logic        ext_evt;
  logic        ext_capture;
  logic        ext_reload;
  logic        wr_cnt;
  logic        wr_rld;
  logic        wr_ctl;

  t3cg_edge_if cnt_pin ();
  t3cg_edge_if stb_pin ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign cnt_pin.pin_raw = ext_count_clock_pin_in;
  assign stb_pin.pin_raw = capture_reload_strobe_pin_in;

  t3cg_pin_sync u_cnt_sync (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .pin  (cnt_pin.det)
  );

  t3cg_pin_sync u_stb_sync (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .pin  (stb_pin.det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode from control and mode bytes
  assign run         = ctrl_q[t3cg_pkg::CTL_RUN];
  assign cts         = ctrl_q[t3cg_pkg::CTL_CTS];
  assign exen        = ctrl_q[t3cg_pkg::CTL_EXT_EN];                   // [R10] [R13]
  assign baud        = ctrl_q[t3cg_pkg::CTL_RX_CLK] | ctrl_q[t3cg_pkg::CTL_TX_CLK]; // [R11]
  assign clkout_mode = mode_q[t3cg_pkg::MODE_CLK_OUT] & ~cts;         // [R1]
  assign fast        = baud | clkout_mode;
  assign capmode     = ctrl_q[t3cg_pkg::CTL_CAPTURE] & ~fast;          // [R10]
  assign updown      = mode_q[t3cg_pkg::MODE_DOWN] & ~fast & ~capmode;
  assign count_up    = ~updown | stb_pin.level;

  // register write decodes
  assign wr_ctl = reg_wr & (reg_addr == t3cg_pkg::ADDR_CONTROL);
  assign wr_cnt = reg_wr & ((reg_addr == t3cg_pkg::ADDR_COUNT_LO) |
                            (reg_addr == t3cg_pkg::ADDR_COUNT_HI));
  assign wr_rld = reg_wr & ((reg_addr == t3cg_pkg::ADDR_RELOAD_LO) |
                            (reg_addr == t3cg_pkg::ADDR_RELOAD_HI));

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: state time in baud/clock-out, slower tick otherwise
  assign pre_lim  = fast ? 4'(t3cg_pkg::STATE_DIV - 1) : 4'(TIMER_DIV - 1); // [R5]
  assign pre_tick = pre_q >= pre_lim;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 4'h0;
    end else if (ce) begin
      if (!run || cts || pre_tick) begin
        pre_q <= 4'h0;
      end else begin
        pre_q <= pre_q + 4'h1;
      end
    end
  end

  // count step: internal tick or pin falling edge
  assign inc = ce & run & (cts ? cnt_pin.fall : pre_tick);            // [R5] [R16] [R13]
  assign ovf = inc & (count_up ? (cnt_q == t3cg_pkg::COUNT_TOP) : (cnt_q == rld_q));

  // strobe edge acts only with external control
  assign ext_evt     = stb_pin.fall & exen;                            // [R14]
  assign ext_capture = ext_evt & capmode;                              // [R15]
  assign ext_reload  = ext_evt & ~baud & ~capmode & ~updown;          // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // next count: overflow reload wins over strobe, software write over both
  always_comb begin
    cnt_d = cnt_q;
    if (ovf) begin
      if (!count_up) begin
        cnt_d = t3cg_pkg::COUNT_TOP;
      end else if (capmode) begin
        cnt_d = cnt_q + 16'h0001;
      end else begin
        cnt_d = rld_q;                                                 // [R18] [R2] [R14]
      end
    end else if (ext_reload) begin
      cnt_d = rld_q;                                                   // [R15]
    end else if (inc) begin
      cnt_d = count_up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
    end
    if (reg_wr && reg_addr == t3cg_pkg::ADDR_COUNT_LO) begin
      cnt_d[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == t3cg_pkg::ADDR_COUNT_HI) begin
      cnt_d[15:8] = reg_wdata;
    end
  end

  // next reload: strobe capture, software byte writes
  always_comb begin
    rld_d = rld_q;
    if (ext_capture) begin
      rld_d = cnt_q;                                                   // [R15]
    end
    if (reg_wr && reg_addr == t3cg_pkg::ADDR_RELOAD_LO) begin
      rld_d[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == t3cg_pkg::ADDR_RELOAD_HI) begin
      rld_d[15:8] = reg_wdata;
    end
  end

  // next control: hardware flag set wins over software clear
  always_comb begin
    ctrl_d = wr_ctl ? reg_wdata : ctrl_q;
    if (ovf && !fast) begin
      ctrl_d[t3cg_pkg::CTL_OVF_FLAG] = 1'b1;                           // [R3]
    end
    if (ext_evt) begin
      ctrl_d[t3cg_pkg::CTL_EXT_FLAG] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= t3cg_pkg::COUNT_RST;
      rld_q  <= t3cg_pkg::RELOAD_RST;
      ctrl_q <= t3cg_pkg::CONTROL_RST;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      rld_q  <= rld_d;
      ctrl_q <= ctrl_d;
    end
  end

  // mode register, upper bits unimplemented
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= t3cg_pkg::MODE_RST;                                    // [R17]
    end else if (ce && reg_wr && reg_addr == t3cg_pkg::ADDR_MODE) begin
      mode_q <= reg_wdata & t3cg_pkg::MODE_MASK;                       // [R17]
    end
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          t3cg_pkg::ADDR_CONTROL:   reg_rdata <= ctrl_q;
          t3cg_pkg::ADDR_MODE:      reg_rdata <= mode_q;
          t3cg_pkg::ADDR_RELOAD_LO: reg_rdata <= rld_q[7:0];
          t3cg_pkg::ADDR_RELOAD_HI: reg_rdata <= rld_q[15:8];
          t3cg_pkg::ADDR_COUNT_LO:  reg_rdata <= cnt_q[7:0];
          t3cg_pkg::ADDR_COUNT_HI:  reg_rdata <= cnt_q[15:8];
          default:                  reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output: toggles on each overflow, half period per overflow
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 1'b0;
    end else if (ce) begin
      if (ovf && clkout_mode) begin
        clk_q <= ~clk_q;                                               // [R18] [R1] [R2]
      end
    end
  end

  assign clock_out_pin_out = clk_q;
  assign clock_out_pin_oe  = mode_q[t3cg_pkg::MODE_CLK_OUT] & ~cts;  // [R1]

  // baud divider: one tick per sixteen overflows, same overflow as clock out
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      baud_cnt_q  <= 4'h0;
      baud_tick_q <= 1'b0;
    end else if (ce) begin
      baud_tick_q <= 1'b0;
      if (ovf && baud) begin
        baud_cnt_q  <= baud_cnt_q + 4'h1;                              // [R4] [R18]
        baud_tick_q <= baud_cnt_q == t3cg_pkg::BAUD_LAST;              // [R8] [R9]
      end
    end
  end

  assign rx_baud_tick = baud_tick_q & ctrl_q[t3cg_pkg::CTL_RX_CLK];  // [R11]
  assign tx_baud_tick = baud_tick_q & ctrl_q[t3cg_pkg::CTL_TX_CLK];  // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_CLKOUT_TOGGLE: assert property (ce && ovf && clkout_mode |=> clk_q != $past(clk_q)) // [R18]
    else $error("clock output did not toggle on overflow");
  AST_NO_FLAG_FAST: assert property (ce && fast && !wr_ctl // [R3]
    |=> ctrl_q[t3cg_pkg::CTL_OVF_FLAG] == $past(ctrl_q[t3cg_pkg::CTL_OVF_FLAG]))
    else $error("overflow flag changed in clock-out or baud mode");
  AST_RELOAD_FAST: assert property (ce && ovf && fast && !wr_cnt |=> cnt_q == $past(rld_q)) // [R2]
    else $error("count not reloaded on overflow");
  AST_STATE_TIME: assert property ((ce && fast && run && !cts) // [R5]
    ##1 (ce && fast && run && !cts) |-> inc != $past(inc))
    else $error("baud mode does not count every state time");
  AST_BAUD_DIV: assert property (ce && ovf && baud && baud_cnt_q == 4'hF |=> baud_tick_q) // [R8]
    else $error("baud tick missing after sixteen overflows");
  AST_BAUD_ONLY16: assert property (baud_tick_q |-> $past(baud_cnt_q) == 4'hF) // [R9]
    else $error("baud tick at wrong overflow count");
  AST_BAUD_NO_STROBE: assert property (ce && ext_evt && baud && !wr_rld // [R15]
    |=> $stable(rld_q))
    else $error("strobe changed reload in baud mode");
  AST_CAPTURE: assert property (ce && ext_evt && capmode && !wr_rld // [R15]
    |=> rld_q == $past(cnt_q))
    else $error("strobe capture missing");
  AST_INTERNAL_ONLY_OVF: assert property (ce && !exen && inc && !ovf // [R14]
    && !wr_cnt && count_up |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count moved other than by one without overflow");
  AST_PIN_COUNT: assert property (ce && run && cts && !cnt_pin.fall // [R16]
    && !ext_reload && !wr_cnt |=> $stable(cnt_q))
    else $error("counter moved without pin edge");
  AST_MODE_BITS: assert property (mode_q[7:2] == 6'h00) // [R17]
    else $error("unimplemented mode bits set");

  COV_CLKOUT: cover property (ce && ovf && clkout_mode);
  COV_BAUD_TICK: cover property (baud_tick_q && ctrl_q[t3cg_pkg::CTL_RX_CLK]);
  COV_CAPTURE: cover property (ext_capture);
  COV_DOWN_UNDERFLOW: cover property (ovf && !count_up);
endmodule
